// ---- rtl/tsps_map.svh ----
// register offsets, field positions, reset values and selector codes for the timing pin select block
`ifndef TSPS_MAP_SVH
`define TSPS_MAP_SVH

`define TSPS_OFS_INT_MASK 8'h01
`define TSPS_OFS_RATIO 8'h0A
`define TSPS_OFS_PIN_SEL 8'h0B
`define TSPS_OFS_SLOW_TRIM 8'h4B
`define TSPS_OFS_FAST_TRIM 8'h4D
`define TSPS_OFS_RATIO_CTRL 8'h50
`define TSPS_OFS_FAST_EN 8'h5F

`define TSPS_BIT_MASK_SLOT_A 5
`define TSPS_BIT_MASK_SLOT_B 6
`define TSPS_BIT_MASK_FIFO 8
`define TSPS_BIT_RATIO_EN 5
`define TSPS_BIT_FAST_EN 0

`define TSPS_RST_INT_MASK 16'h01FF
`define TSPS_RST_PIN_SEL 16'h0000
`define TSPS_RST_SLOW_TRIM 6'h00
`define TSPS_RST_FAST_TRIM 8'h98

`define TSPS_SEL_INT 5'h01
`define TSPS_SEL_WINDOW 5'h02
`define TSPS_SEL_LED_A 5'h05
`define TSPS_SEL_LED_B 5'h06
`define TSPS_SEL_LED_AB 5'h07
`define TSPS_SEL_DATA_A 5'h0C
`define TSPS_SEL_DATA_B 5'h0D
`define TSPS_SEL_DATA_AB 5'h0E
`define TSPS_SEL_HALF 5'h0F
`define TSPS_SEL_ZERO 5'h10
`define TSPS_SEL_ONE 5'h11
`define TSPS_SEL_SLOW_OSC 5'h13

`define TSPS_MODE_STANDBY 2'h0
`define TSPS_MODE_PROGRAM 2'h1
`define TSPS_MODE_NORMAL 2'h2

`define TSPS_RATIO_SLOW_PERIODS 2
`define TSPS_RATIO_NOMINAL 12'h7D0

`endif

// ---- rtl/tsps_pkg.sv ----
// types shared by the timing pin select block
package tsps_pkg;
  // per-pin driver configuration
  typedef struct packed {
    logic openDrain;
    logic invert;
  } tsps_pin_cfg_t;
  // two-signal view of one output pin
  typedef struct packed {
    logic out;
    logic oe;
  } tsps_pin_drive_t;
  // ratio measurement sequence
  typedef enum logic [1:0] {
    TSPS_RATIO_IDLE,
    TSPS_RATIO_ARM,
    TSPS_RATIO_COUNT,
    TSPS_RATIO_DONE
  } tsps_ratio_state_t;
endpackage

// ---- rtl/tsps_sync.sv ----
// three-stage synchroniser; output moves only when stages two and three agree
`timescale 1ns/1ps
module tsps_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic async,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 is read by stage2 alone, so a metastable sample never reaches logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a change only once it has been seen twice
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      level <= 1'b0;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule

// ---- rtl/tsps_ratio_counter.sv ----
// counts fast-clock cycles across two slow-clock periods
`timescale 1ns/1ps
`include "tsps_map.svh"
module tsps_ratio_counter
  import tsps_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic slowRise,
  output logic [WIDTH-1:0] ratio,
  output logic done
);
  localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
  tsps_ratio_state_t state;
  logic [WIDTH-1:0] count;
  logic [1:0] edges;

  // measurement sequence; dropping enable aborts and clears everything
  always_ff @(posedge ref_clk) begin
    if (reset || !enable) begin
      state <= TSPS_RATIO_IDLE;
      count <= '0;
      edges <= 2'h0;
      ratio <= '0;
      done <= 1'b0;
    end else begin
      case (state)
        TSPS_RATIO_IDLE: begin
          state <= TSPS_RATIO_ARM;
        end
        TSPS_RATIO_ARM: begin
          if (slowRise) begin
            state <= TSPS_RATIO_COUNT;
            // the arming edge already opens the first counted fast cycle
            count <= WIDTH'(1);
            edges <= 2'h0;
          end
        end
        TSPS_RATIO_COUNT: begin
          // saturate rather than wrap so a slow clock never reads as fast
          if (count != MAX_COUNT) begin
            count <= count + 1'b1;
          end
          if (slowRise) begin
            edges <= edges + 2'h1;
            if (edges == 2'(`TSPS_RATIO_SLOW_PERIODS - 1)) begin
              ratio <= count;
              done <= 1'b1;
              state <= TSPS_RATIO_DONE;
            end
          end
        end
        TSPS_RATIO_DONE: begin
          state <= TSPS_RATIO_DONE;
        end
        default: begin
          state <= TSPS_RATIO_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- rtl/tsps_top.sv ----
// timing signal pin select: register file, calibration support and two timing output pins
`timescale 1ns/1ps
`include "tsps_map.svh"
module tsps_top
  import tsps_pkg::*;
#(
  parameter int RATIO_WIDTH = 12,
  parameter int SEL_WIDTH = 5
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic [1:0] opMode,
  input wire logic sampleStart,
  input wire logic sampleEnd,
  input wire logic [1:0] dataWritten,
  input wire logic [1:0] ledPulse,
  input wire logic fifoIrq,
  input wire logic [1:0] intClear,
  input wire logic slowOscClk,
  input wire tsps_pin_cfg_t pinCfgZero,
  input wire tsps_pin_cfg_t pinCfgOne,
  output logic [1:0] sampleIntFlag,
  output logic fastOscEnable,
  output logic [7:0] fastOscTrim,
  output logic [5:0] slowOscTrim,
  output logic pinZeroOut,
  output logic pinZeroOe,
  output logic pinOneOut,
  output logic pinOneOe
);
  // software-visible state, plus the ratio done flag that nothing reads
  logic [15:0] intMask;
  logic [15:0] pinSelect;
  logic ratioCountEnable;
  logic [RATIO_WIDTH-1:0] ratioValue;
  logic ratioDone;

  // timing state seen by the selectors and the ratio counter
  logic slowLevel;
  logic slowLevelDly;
  logic slowRise;
  logic sampleWindow;
  logic [1:0] dataCycle;
  logic halfRateToggle;
  logic [1:0] modeDly;
  logic modeToNormal;
  logic intLine;

  // per-pin selector view
  logic [1:0][SEL_WIDTH-1:0] pinCode;
  tsps_pin_cfg_t [1:0] pinCfg;
  logic [1:0] pinLevel;
  tsps_pin_drive_t [1:0] pinDrive;
  logic [1:0] slotIntEnable;

  // map a selector code to its raw timing level; unknown codes stay inactive
  function automatic logic selectLevel(input logic [SEL_WIDTH-1:0] code);
    logic level;
    level = 1'b0;
    case (code)
      `TSPS_SEL_INT: level = intLine;
      `TSPS_SEL_WINDOW: level = sampleWindow;
      `TSPS_SEL_LED_A: level = ledPulse[0];
      `TSPS_SEL_LED_B: level = ledPulse[1];
      `TSPS_SEL_LED_AB: level = |ledPulse;
      `TSPS_SEL_DATA_A: level = dataCycle[0];
      `TSPS_SEL_DATA_B: level = dataCycle[1];
      `TSPS_SEL_DATA_AB: level = |dataCycle;
      `TSPS_SEL_HALF: level = halfRateToggle;
      `TSPS_SEL_ZERO: level = 1'b0;
      `TSPS_SEL_ONE: level = 1'b1;
      `TSPS_SEL_SLOW_OSC: level = slowLevel;
      default: level = 1'b0;
    endcase
    return level;
  endfunction

  // register writes at the documented offsets
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intMask <= `TSPS_RST_INT_MASK;
      pinSelect <= `TSPS_RST_PIN_SEL;
      slowOscTrim <= `TSPS_RST_SLOW_TRIM;
      fastOscTrim <= `TSPS_RST_FAST_TRIM;
      ratioCountEnable <= 1'b0;
      fastOscEnable <= 1'b0;
    end else if (regWrite) begin
      case (regAddr)
        `TSPS_OFS_INT_MASK: intMask <= regWrData;
        `TSPS_OFS_PIN_SEL: pinSelect <= regWrData;
        // larger trim slows the slow oscillator; the analog side owns the sense
        `TSPS_OFS_SLOW_TRIM: slowOscTrim <= regWrData[5:0];
        `TSPS_OFS_FAST_TRIM: fastOscTrim <= regWrData[7:0];
        `TSPS_OFS_RATIO_CTRL: ratioCountEnable <= regWrData[`TSPS_BIT_RATIO_EN];
        `TSPS_OFS_FAST_EN: fastOscEnable <= regWrData[`TSPS_BIT_FAST_EN];
        default: begin
        end
      endcase
    end
  end

  // registered readback; unmapped offsets read as zero, as do unused bits of the trim, ratio and enable registers; mask and selector read back all 16 bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdData <= 16'h0000;
    end else begin
      case (regAddr)
        `TSPS_OFS_INT_MASK: regRdData <= intMask;
        `TSPS_OFS_RATIO: regRdData <= 16'(ratioValue);
        `TSPS_OFS_PIN_SEL: regRdData <= pinSelect;
        `TSPS_OFS_SLOW_TRIM: regRdData <= 16'(slowOscTrim);
        `TSPS_OFS_FAST_TRIM: regRdData <= 16'(fastOscTrim);
        `TSPS_OFS_RATIO_CTRL: regRdData <= 16'(ratioCountEnable) << `TSPS_BIT_RATIO_EN;
        `TSPS_OFS_FAST_EN: regRdData <= 16'(fastOscEnable);
        default: regRdData <= 16'h0000;
      endcase
    end
  end

  // slow oscillator arrives asynchronously and must be cleaned up first
  tsps_sync u_slow_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async(slowOscClk),
    .level(slowLevel)
  );

  // edge of the already-synchronised slow clock
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slowLevelDly <= 1'b0;
    end else begin
      slowLevelDly <= slowLevel;
    end
  end
  assign slowRise = slowLevel & ~slowLevelDly;

  // ref_clk is the fast time base, counted against two slow periods
  tsps_ratio_counter #(
    .WIDTH(RATIO_WIDTH)
  ) u_ratio (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(ratioCountEnable),
    .slowRise(slowRise),
    .ratio(ratioValue),
    .done(ratioDone)
  );

  // per-slot sample interrupt flags; a new sample beats a same-cycle clear
  assign slotIntEnable[0] = ~intMask[`TSPS_BIT_MASK_SLOT_A];
  assign slotIntEnable[1] = ~intMask[`TSPS_BIT_MASK_SLOT_B];
  for (genvar s = 0; s < 2; s++) begin : g_slot
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        sampleIntFlag[s] <= 1'b0;
      end else if (dataWritten[s] && slotIntEnable[s]) begin
        sampleIntFlag[s] <= 1'b1;
      end else if (intClear[s]) begin
        sampleIntFlag[s] <= 1'b0;
      end
    end

    // data cycle flag: set at slot end, dropped at next sample start
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        dataCycle[s] <= 1'b0;
      end else if (dataWritten[s]) begin
        dataCycle[s] <= 1'b1;
      end else if (sampleStart) begin
        dataCycle[s] <= 1'b0;
      end
    end
  end

  // interrupt line combines the sample flags and the unmasked fifo request
  assign intLine = (|sampleIntFlag) | (fifoIrq & ~intMask[`TSPS_BIT_MASK_FIFO]);

  // sample window spans first enabled slot start to last enabled slot end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sampleWindow <= 1'b0;
    end else if (sampleStart) begin
      sampleWindow <= 1'b1;
    end else if (sampleEnd) begin
      sampleWindow <= 1'b0;
    end
  end

  // mode history to spot the standby to normal step
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      modeDly <= `TSPS_MODE_STANDBY;
    end else begin
      modeDly <= opMode;
    end
  end
  assign modeToNormal = (modeDly == `TSPS_MODE_STANDBY) && (opMode == `TSPS_MODE_NORMAL);

  // half-rate toggle: forced low on the standby to normal step, flips at every sample end in normal mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      halfRateToggle <= 1'b0;
    end else if (modeToNormal) begin
      halfRateToggle <= 1'b0;
    end else if (sampleEnd && opMode == `TSPS_MODE_NORMAL) begin
      halfRateToggle <= ~halfRateToggle;
    end
  end

  // whole selector zero falls back to interrupt on pin zero, window on pin one
  always_comb begin
    if (pinSelect == 16'h0000) begin
      pinCode[0] = `TSPS_SEL_INT;
      pinCode[1] = `TSPS_SEL_WINDOW;
    end else begin
      pinCode[0] = pinSelect[4:0];
      pinCode[1] = pinSelect[12:8];
    end
  end

  assign pinCfg[0] = pinCfgZero;
  assign pinCfg[1] = pinCfgOne;

  // selector function reads module state, so a process keeps it sensitive to all of it
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pinLevel[p] = selectLevel(pinCode[p]) ^ pinCfg[p].invert;
    end
  end

  // selection, polarity and driver type per pin, registered to keep pins glitch free
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pinDrive[p] <= '{out: 1'b0, oe: 1'b0};
      end else if (pinCfg[p].openDrain) begin
        // open drain only ever pulls low; high is left to the shared pull-up
        pinDrive[p] <= '{out: 1'b0, oe: ~pinLevel[p]};
      end else begin
        pinDrive[p] <= '{out: pinLevel[p], oe: 1'b1};
      end
    end
  end

  assign pinZeroOut = pinDrive[0].out;
  assign pinZeroOe = pinDrive[0].oe;
  assign pinOneOut = pinDrive[1].out;
  assign pinOneOe = pinDrive[1].oe;
endmodule

// ---- tb/tsps_host_model.sv ----
// host side of the timing pins: board pull-ups and an edge counter on pin zero
`timescale 1ns/1ps
module tsps_host_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pinZeroOut,
  input wire logic pinZeroOe,
  input wire logic pinOneOut,
  input wire logic pinOneOe,
  output logic wireZero,
  output logic wireOne,
  output int zeroRises
);
  logic lastZero;
  // a released pin floats high through the pull-up, never holds its last value
  assign wireZero = pinZeroOe ? pinZeroOut : 1'b1;
  assign wireOne = pinOneOe ? pinOneOut : 1'b1;
  // sample-rate measurement: count rising edges seen on pin zero
  always @(posedge ref_clk) begin
    lastZero <= wireZero;
    if (reset)
      zeroRises <= 0;
    else if (wireZero && !lastZero)
      zeroRises <= zeroRises + 1;
  end
endmodule

// ---- tb/tsps_chk.sv ----
// concurrent checks on the timing pin select top ports
`timescale 1ns/1ps
`include "tsps_map.svh"
module tsps_chk
  import tsps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic [1:0] opMode,
  input wire logic sampleStart,
  input wire logic sampleEnd,
  input wire logic [1:0] dataWritten,
  input wire tsps_pin_cfg_t pinCfgZero,
  input wire tsps_pin_cfg_t pinCfgOne,
  input wire logic [1:0] sampleIntFlag,
  input wire logic [7:0] fastOscTrim,
  input wire logic pinZeroOut,
  input wire logic pinOneOut,
  input wire logic pinOneOe
);
  logic [4:0] selZero;
  logic [4:0] selOne;
  logic maskA;
  logic ratioEn;
  logic [7:0] wrLow;
  logic legacyOne;
  logic halfZero;
  logic dataB;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // selector cases seen on plain pins: driven and not inverted
  assign wrLow = regWrData[7:0];
  assign legacyOne = !pinCfgOne.openDrain && !pinCfgOne.invert && selZero == 5'h00 && selOne == 5'h00;
  assign halfZero = !pinCfgZero.openDrain && !pinCfgZero.invert && selZero == `TSPS_SEL_HALF;
  assign dataB = !pinCfgOne.openDrain && !pinCfgOne.invert && selOne == `TSPS_SEL_DATA_B;
  // shadow of the pin selector, slot A mask and ratio enable registers, landing on the write edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      selZero <= 5'h00;
      selOne <= 5'h00;
      maskA <= 1'b1;
      ratioEn <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == `TSPS_OFS_PIN_SEL) begin
        selZero <= regWrData[4:0];
        selOne <= regWrData[12:8];
      end
      if (regAddr == `TSPS_OFS_INT_MASK)
        maskA <= regWrData[5];
      if (regAddr == `TSPS_OFS_RATIO_CTRL)
        ratioEn <= regWrData[5];
    end
  end
  property p_fast_trim;
    regWrite && regAddr == `TSPS_OFS_FAST_TRIM |=> fastOscTrim == $past(wrLow);
  endproperty
  a_fast_trim: assert property (p_fast_trim) else $error("fast trim not taken");
  property p_const_zero;
    $past(selOne) == `TSPS_SEL_ZERO && !$past(pinCfgOne.openDrain)
      |-> pinOneOe && pinOneOut == $past(pinCfgOne.invert);
  endproperty
  a_const_zero: assert property (p_const_zero) else $error("constant level wrong");
  property p_open_drain;
    $past(pinCfgOne.openDrain) |-> !pinOneOut;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");
  property p_legacy_window;
    (sampleStart && !sampleEnd && legacyOne) ##1 legacyOne |=> pinOneOut;
  endproperty
  a_legacy_window: assert property (p_legacy_window) else $error("window missing on pin one");
  property p_half_restart;
    (opMode == `TSPS_MODE_NORMAL && $past(opMode) == `TSPS_MODE_STANDBY && halfZero) ##1 halfZero |=> !pinZeroOut;
  endproperty
  a_half_restart: assert property (p_half_restart) else $error("half rate not low at start");
  property p_data_b;
    (dataWritten[1] && dataB) ##1 dataB |=> pinOneOut;
  endproperty
  a_data_b: assert property (p_data_b) else $error("data cycle missing");
  property p_flag_a;
    dataWritten[0] && !maskA |=> sampleIntFlag[0];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("sample flag not raised");
  property p_ratio_clear;
    !ratioEn && !$past(ratioEn) && !$past(ratioEn, 2) && $past(regAddr) == `TSPS_OFS_RATIO |-> regRdData == 16'h0000;
  endproperty
  a_ratio_clear: assert property (p_ratio_clear) else $error("ratio not cleared");
endmodule
bind tsps_top tsps_chk u_tsps_chk (.ref_clk, .reset, .regWrite, .regAddr, .regWrData, .regRdData, .opMode,
  .sampleStart, .sampleEnd, .dataWritten, .pinCfgZero, .pinCfgOne, .sampleIntFlag, .fastOscTrim,
  .pinZeroOut, .pinOneOut, .pinOneOe);

// ---- tb/timing_signal_pin_select_tb.sv ----
// self-checking testbench for the timing pin select block
`timescale 1ns/1ps
`include "tsps_map.svh"
module timing_signal_pin_select_tb
  import tsps_pkg::*;
;
  logic ref_clk, reset, regWrite, sampleStart, sampleEnd, fifoIrq, slowOscClk;
  logic fastOscEnable, pinZeroOut, pinZeroOe, pinOneOut, pinOneOe, wireZero, wireOne;
  logic [7:0] regAddr, fastOscTrim;
  logic [15:0] regWrData, regRdData;
  logic [1:0] opMode, dataWritten, ledPulse, intClear, sampleIntFlag;
  logic [5:0] slowOscTrim;
  tsps_pin_cfg_t pinCfgZero, pinCfgOne;
  int zeroRises, n_errors, checks, slowCnt;
  tsps_top u_tsps_top (.ref_clk, .reset, .regWrite, .regAddr, .regWrData, .regRdData, .opMode,
    .sampleStart, .sampleEnd, .dataWritten, .ledPulse, .fifoIrq, .intClear, .slowOscClk, .pinCfgZero,
    .pinCfgOne, .sampleIntFlag, .fastOscEnable, .fastOscTrim, .slowOscTrim, .pinZeroOut, .pinZeroOe,
    .pinOneOut, .pinOneOe);
  tsps_host_model u_tsps_host_model (.ref_clk, .reset, .pinZeroOut, .pinZeroOe, .pinOneOut, .pinOneOe,
    .wireZero, .wireOne, .zeroRises);
  // 200 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // slow oscillator stand-in, forty fast cycles a period so ratio runs stay short
  always @(posedge ref_clk) begin
    slowCnt <= (slowCnt == 19) ? 0 : slowCnt + 1;
    if (slowCnt == 19)
      slowOscClk <= ~slowOscClk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    cyc(2);
    chk(regRdData, exp);
  endtask
  // one-cycle event pulse: {intClear, dataWritten, sampleEnd, sampleStart}
  task automatic pulse(input logic [5:0] v);
    @(posedge ref_clk);
    {intClear, dataWritten, sampleEnd, sampleStart} <= v;
    @(posedge ref_clk);
    {intClear, dataWritten, sampleEnd, sampleStart} <= 6'h00;
    cyc(2);
  endtask
  task automatic sel(input logic [4:0] one, input logic [4:0] zero);
    wr(`TSPS_OFS_PIN_SEL, {3'h0, one, 3'h0, zero});
  endtask
  task automatic pins(input logic [1:0] e);
    chk({14'h0000, pinOneOut, pinZeroOut}, {14'h0000, e});
    chk({14'h0000, wireOne, wireZero}, {14'h0000, e});
  endtask
  task automatic t_regs;
    rd(`TSPS_OFS_FAST_TRIM, 16'h0098);
    rd(`TSPS_OFS_INT_MASK, 16'h01FF);
    rd(8'h33, 16'h0000);
    wr(`TSPS_OFS_FAST_TRIM, 16'hFF67);
    rd(`TSPS_OFS_FAST_TRIM, 16'h0067);
    wr(`TSPS_OFS_SLOW_TRIM, 16'hFFFF);
    chk({10'h000, slowOscTrim}, 16'h003F);
    wr(`TSPS_OFS_RATIO, 16'hFFFF);
    rd(`TSPS_OFS_RATIO, 16'h0000);
  endtask
  // two slow periods of forty fast cycles, exact since the stand-in is locked to ref_clk
  task automatic t_ratio;
    wr(`TSPS_OFS_FAST_TRIM, 16'h0098);
    wr(`TSPS_OFS_FAST_EN, 16'h0001);
    chk({15'h0000, fastOscEnable}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      wr(`TSPS_OFS_RATIO_CTRL, 16'h0020);
      rd(`TSPS_OFS_RATIO, 16'h0000);
      cyc(200);
      rd(`TSPS_OFS_RATIO, 16'h0050);
      cyc(50);
      chk(regRdData, 16'h0050);
      wr(`TSPS_OFS_RATIO_CTRL, 16'h0000);
      rd(`TSPS_OFS_RATIO, 16'h0000);
    end
    wr(`TSPS_OFS_FAST_EN, 16'h0000);
    chk({15'h0000, fastOscEnable}, 16'h0000);
  endtask
  task automatic t_irq;
    int base;
    wr(`TSPS_OFS_INT_MASK, 16'h01DF);
    pulse(6'h04);
    pins(2'b01);
    pulse(6'h10);
    pins(2'b00);
    pulse(6'h01);
    pins(2'b10);
    pulse(6'h02);
    pins(2'b00);
    sel(`TSPS_SEL_ZERO, `TSPS_SEL_INT);
    base = zeroRises;
    for (int i = 0; i < 3; i++) begin
      pulse(6'h04);
      pulse(6'h10);
    end
    chk(16'(zeroRises - base), 16'h0003);
    wr(`TSPS_OFS_INT_MASK, 16'h01FF);
    pulse(6'h04);
    pins(2'b00);
    // fifo request reaches the pin only once its mask bit is cleared
    fifoIrq <= 1'b1;
    cyc(3);
    pins(2'b00);
    wr(`TSPS_OFS_INT_MASK, 16'h00FF);
    pins(2'b01);
    fifoIrq <= 1'b0;
    cyc(3);
    pins(2'b00);
    wr(`TSPS_OFS_INT_MASK, 16'h01FF);
  endtask
  task automatic t_copies;
    logic [4:0] code [6] = '{`TSPS_SEL_LED_A, `TSPS_SEL_LED_B, `TSPS_SEL_LED_AB,
      `TSPS_SEL_DATA_A, `TSPS_SEL_DATA_B, `TSPS_SEL_DATA_AB};
    logic [5:0] exp = 6'b110101;
    @(posedge ref_clk);
    ledPulse <= 2'b01;
    sel(`TSPS_SEL_DATA_B, `TSPS_SEL_ZERO);
    pulse(6'h09);
    for (int i = 0; i < 6; i++) begin
      sel(code[i], `TSPS_SEL_ZERO);
      pins({exp[i], 1'b0});
    end
    pulse(6'h01);
    pins(2'b00);
    ledPulse <= 2'b00;
  endtask
  task automatic t_drive;
    sel(`TSPS_SEL_ONE, `TSPS_SEL_ZERO);
    pins(2'b10);
    pinCfgZero <= 2'b01;
    sel(`TSPS_SEL_ZERO, 5'h1F);
    pins(2'b01);
    pinCfgOne <= 2'b10;
    sel(`TSPS_SEL_ONE, 5'h1F);
    chk({14'h0000, pinOneOe, wireOne}, 16'h0001);
    sel(`TSPS_SEL_ZERO, 5'h1F);
    chk({14'h0000, pinOneOe, wireOne}, 16'h0002);
    pinCfgZero <= 2'b00;
    pinCfgOne <= 2'b00;
  endtask
  task automatic t_half;
    sel(`TSPS_SEL_ZERO, `TSPS_SEL_HALF);
    opMode <= `TSPS_MODE_NORMAL;
    cyc(3);
    pins(2'b00);
    for (int i = 0; i < 3; i++) begin
      pulse(6'h02);
      pins({1'b0, i[0] == 1'b0});
    end
    @(posedge ref_clk);
    opMode <= `TSPS_MODE_STANDBY;
    cyc(2);
    opMode <= `TSPS_MODE_NORMAL;
    cyc(3);
    pins(2'b00);
  endtask
  task automatic t_slow;
    sel(`TSPS_SEL_ZERO, `TSPS_SEL_SLOW_OSC);
    @(posedge slowOscClk);
    cyc(8);
    pins(2'b01);
    @(negedge slowOscClk);
    cyc(8);
    pins(2'b00);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs about eight hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict;
  end
  initial begin
    reset = 1'b1;
    {regWrite, sampleStart, sampleEnd, fifoIrq, slowOscClk} = 5'h00;
    {dataWritten, ledPulse, intClear, opMode} = 8'h00;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    pinCfgZero = 2'b00;
    pinCfgOne = 2'b00;
    {slowCnt, n_errors, checks} = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    cyc(1);
    t_regs;
    t_ratio;
    t_irq;
    t_copies;
    t_drive;
    t_half;
    t_slow;
    print_verdict;
  end
endmodule
